// ===== host_model.sv
`timescale 1ns/1ps
module host_model (
    // Clock
    input wire logic clock,
    // Command port
    output ov_fault_pkg::cmd_req_type cmd_req,
    input wire logic [15:0] rd_data,
    input wire logic rd_ack
);
    initial cmd_req = '0;
    // Released bus shows inverted leftovers
    task automatic idle();
        cmd_req.wr_valid <= 1'h0;
        cmd_req.rd_valid <= 1'h0;
        cmd_req.code <= ~cmd_req.code;
        cmd_req.data <= ~cmd_req.data;
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge clock);
        cmd_req <= '{1'h1, 1'h0, c, d};
        @(posedge clock);
        idle();
    endtask
    task automatic rd(input logic [7:0] c, output logic [15:0] d,
                      output logic a);
        @(posedge clock);
        cmd_req <= '{1'h0, 1'h1, c, ~cmd_req.data};
        @(posedge clock);
        idle();
        @(posedge clock);
        d = rd_data;
        a = rd_ack;
    endtask
endmodule

// ===== input_overvoltage_fault_handler.sv
`timescale 1ns/1ps
`include "ov_fault_params.svh"

module input_overvoltage_fault_handler (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Command port
    input wire ov_fault_pkg::cmd_req_type cmd_req,
    output logic [15:0] rd_data,
    output logic rd_ack,
    output logic cmd_error,
    // Measurement and control
    input wire logic [15:0] vin_measured,
    input wire ov_fault_pkg::control_in_type control_in,
    // Status
    output logic output_enable,
    output logic ov_fault,
    output logic fault_latched,
    output logic [2:0] retry_attempts
);

    ov_fault_pkg::core_type core_r;
    ov_fault_pkg::core_type core_nxt;

    logic ov_now;
    logic timer_done;
    logic [2:0] retry_limit;
    logic [2:0] retry_time;
    logic [1:0] response;
    logic stop_all;

    // Linear value as signed fixed point scaled by 2^16
    function automatic logic signed [47:0] linear_to_fixed(
        input logic [15:0] v
    );
        logic signed [47:0] m;
        logic [4:0] sh;
        m = {{37{v[10]}}, v[10:0]};
        sh = {~v[15], v[14:11]};
        return m <<< sh;
    endfunction

    // Number of delay units for a retry time code
    function automatic logic [7:0] delay_units(input logic [2:0] code);
        return 8'h01 << code;
    endfunction

    // Base periods per delay unit, never below one
    function automatic logic [15:0] unit_reload(input logic [15:0] unit);
        if (unit == 16'h0000) begin
            return 16'h0000;
        end
        return unit - 16'h0001;
    endfunction

    // Field decode
    assign response = core_r.action[`ACT_RESP_HI:`ACT_RESP_LO];
    assign retry_limit = core_r.action[`ACT_RETRY_HI:`ACT_RETRY_LO];
    assign retry_time = core_r.action[`ACT_TIME_HI:`ACT_TIME_LO];

    // Overvoltage compare
    assign ov_now = linear_to_fixed(vin_measured) >
        linear_to_fixed(core_r.threshold);

    // Commanded off, bias lost or another fault ends every sequence
    assign stop_all = !control_in.commanded_on || !control_in.bias_ok ||
        control_in.other_fault;

    // Timer ends when all three counters are exhausted
    assign timer_done = (core_r.cyc_cnt == 6'h00) &&
        (core_r.base_cnt == 16'h0000) &&
        (core_r.unit_cnt == 8'h00);

    // Next-state logic
    always_comb begin
        core_nxt = core_r;
        core_nxt.rd_ack = 1'b0;
        core_nxt.cmd_error = 1'b0;
        core_nxt.ov = ov_now;

        // Command writes
        if (cmd_req.wr_valid) begin
            case (cmd_req.code)
                `CMD_OV_FAULT_THRESHOLD: begin
                    core_nxt.threshold = cmd_req.data;
                end
                `CMD_OV_FAULT_ACTION: begin
                    core_nxt.action = cmd_req.data[7:0];
                end
                `CMD_DELAY_UNIT: begin
                    core_nxt.delay_unit = cmd_req.data;
                end
                default: begin
                    core_nxt.cmd_error = 1'b1;
                end
            endcase
        end

        // Command reads
        if (cmd_req.rd_valid) begin
            core_nxt.rd_ack = 1'b1;
            case (cmd_req.code)
                `CMD_OV_FAULT_THRESHOLD: begin
                    core_nxt.rd_data = core_r.threshold;
                end
                `CMD_OV_FAULT_ACTION: begin
                    core_nxt.rd_data = {8'h00, core_r.action};
                end
                `CMD_DELAY_UNIT: begin
                    core_nxt.rd_data = core_r.delay_unit;
                end
                `CMD_OV_STATUS: begin
                    core_nxt.rd_data = {7'h00, core_r.attempts,
                        core_r.state};
                end
                default: begin
                    core_nxt.rd_data = 16'h0000;
                    core_nxt.cmd_error = 1'b1;
                end
            endcase
        end

        // Delay timer countdown
        if (!timer_done) begin
            if (core_r.cyc_cnt != 6'h00) begin
                core_nxt.cyc_cnt = core_r.cyc_cnt - 6'h01;
            end else begin
                core_nxt.cyc_cnt = 6'(`UNIT_BASE_CYCLES - 1);
                if (core_r.base_cnt != 16'h0000) begin
                    core_nxt.base_cnt = core_r.base_cnt - 16'h0001;
                end else begin
                    core_nxt.base_cnt = unit_reload(core_r.delay_unit);
                    core_nxt.unit_cnt = core_r.unit_cnt - 8'h01;
                end
            end
        end

        // Fault sequencing
        case (core_r.state)
            ov_fault_pkg::ST_RUN: begin
                core_nxt.output_on = 1'b1;
                core_nxt.attempts = 3'h0;
                if (ov_now) begin
                    case (response)
                        `RESP_IGNORE: begin
                            core_nxt.state = ov_fault_pkg::ST_RUN;
                        end
                        `RESP_TOLERATE: begin
                            core_nxt.state = ov_fault_pkg::ST_TOLERATE;
                            core_nxt.cyc_cnt = 6'(`UNIT_BASE_CYCLES - 1);
                            core_nxt.base_cnt =
                                unit_reload(core_r.delay_unit);
                            core_nxt.unit_cnt =
                                delay_units(retry_time) - 8'h01;
                        end
                        `RESP_DISABLE_RETRY: begin
                            core_nxt.output_on = 1'b0;
                            if (retry_limit == `RETRY_NONE) begin
                                core_nxt.state =
                                    ov_fault_pkg::ST_LATCHED;
                            end else begin
                                core_nxt.state = ov_fault_pkg::ST_RETRY_WAIT;
                                core_nxt.cyc_cnt =
                                    6'(`UNIT_BASE_CYCLES - 1);
                                core_nxt.base_cnt =
                                    unit_reload(core_r.delay_unit);
                                core_nxt.unit_cnt =
                                    delay_units(retry_time) - 8'h01;
                            end
                        end
                        default: begin
                            core_nxt.output_on = 1'b0;
                            core_nxt.state =
                                ov_fault_pkg::ST_HOLD_OFF;
                        end
                    endcase
                end
            end

            ov_fault_pkg::ST_TOLERATE: begin
                core_nxt.output_on = 1'b1;
                // A fault that clears during the delay is forgiven
                if (!ov_now) begin
                    core_nxt.state = ov_fault_pkg::ST_RUN;
                end else if (timer_done) begin
                    core_nxt.output_on = 1'b0;
                    if (retry_limit == `RETRY_NONE) begin
                        core_nxt.state = ov_fault_pkg::ST_LATCHED;
                    end else begin
                        core_nxt.state = ov_fault_pkg::ST_RETRY_WAIT;
                        core_nxt.cyc_cnt = 6'(`UNIT_BASE_CYCLES - 1);
                        core_nxt.base_cnt = unit_reload(core_r.delay_unit);
                        core_nxt.unit_cnt =
                            delay_units(retry_time) - 8'h01;
                    end
                end
            end

            ov_fault_pkg::ST_RETRY_WAIT: begin
                core_nxt.output_on = 1'b0;
                if (timer_done) begin
                    // Unlimited retries are not counted
                    if (retry_limit != `RETRY_FOREVER) begin
                        core_nxt.attempts =
                            core_r.attempts + 3'h1;
                    end
                    if (!ov_now) begin
                        core_nxt.state = ov_fault_pkg::ST_RUN;
                        core_nxt.output_on = 1'b1;
                    end else if (retry_limit != `RETRY_FOREVER &&
                        core_r.attempts + 3'h1 >= retry_limit) begin
                        core_nxt.state = ov_fault_pkg::ST_LATCHED;
                    end else begin
                        core_nxt.cyc_cnt = 6'(`UNIT_BASE_CYCLES - 1);
                        core_nxt.base_cnt = unit_reload(core_r.delay_unit);
                        core_nxt.unit_cnt =
                            delay_units(retry_time) - 8'h01;
                    end
                end
            end

            ov_fault_pkg::ST_HOLD_OFF: begin
                core_nxt.output_on = 1'b0;
                if (!ov_now) begin
                    core_nxt.state = ov_fault_pkg::ST_RUN;
                    core_nxt.output_on = 1'b1;
                end
            end

            ov_fault_pkg::ST_LATCHED: begin
                core_nxt.output_on = 1'b0;
                if (control_in.clear_fault) begin
                    core_nxt.state = ov_fault_pkg::ST_RUN;
                end
            end

            ov_fault_pkg::ST_OFF: begin
                core_nxt.output_on = 1'b0;
                core_nxt.attempts = 3'h0;
                if (!stop_all) begin
                    core_nxt.state = ov_fault_pkg::ST_RUN;
                end
            end
            default: begin
                core_nxt.state = ov_fault_pkg::ST_OFF;
                core_nxt.output_on = 1'b0;
            end
        endcase

        // Shutdown from outside overrides the sequence
        if (stop_all) begin
            core_nxt.state = ov_fault_pkg::ST_OFF;
            core_nxt.output_on = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            core_r.state <= ov_fault_pkg::ST_OFF;
            core_r.threshold <= `RST_OV_FAULT_THRESHOLD;
            core_r.action <= `RST_OV_FAULT_ACTION;
            core_r.delay_unit <= `RST_DELAY_UNIT;
            core_r.cyc_cnt <= 6'h00;
            core_r.base_cnt <= 16'h0000;
            core_r.unit_cnt <= 8'h00;
            core_r.attempts <= 3'h0;
            core_r.ov <= 1'b0;
            core_r.output_on <= 1'b0;
            core_r.rd_data <= 16'h0000;
            core_r.rd_ack <= 1'b0;
            core_r.cmd_error <= 1'b0;
        end else begin
            core_r <= core_nxt;
        end
    end

    // Outputs come straight from the core flops
    assign rd_data = core_r.rd_data;
    assign rd_ack = core_r.rd_ack;
    assign cmd_error = core_r.cmd_error;
    assign output_enable = core_r.output_on;
    assign ov_fault = core_r.ov;
    // Latched state is one-hot bit 4, read straight from its flop
    assign fault_latched = core_r.state[4];
    assign retry_attempts = core_r.attempts;

endmodule

// ===== ov_fault_params.svh
`ifndef OV_FAULT_PARAMS_SVH
`define OV_FAULT_PARAMS_SVH

// Command codes
`define CMD_OV_FAULT_THRESHOLD 8'h55
`define CMD_OV_FAULT_ACTION 8'h56
`define CMD_DELAY_UNIT 8'hD2
`define CMD_OV_STATUS 8'hE8

// Reset values
`define RST_OV_FAULT_THRESHOLD 16'h7BFF
`define RST_OV_FAULT_ACTION 8'h80
`define RST_DELAY_UNIT 16'h03E8

// Action field positions
`define ACT_RESP_HI 7
`define ACT_RESP_LO 6
`define ACT_RETRY_HI 5
`define ACT_RETRY_LO 3
`define ACT_TIME_HI 2
`define ACT_TIME_LO 0

// Response and retry codes
`define RESP_IGNORE 2'h0
`define RESP_TOLERATE 2'h1
`define RESP_DISABLE_RETRY 2'h2
`define RESP_RESUME_WHEN_OK 2'h3
`define RETRY_NONE 3'h0
`define RETRY_FOREVER 3'h7

// Timing: one delay unit is a register count of base periods
`define CLOCK_PERIOD_NS 25
`define UNIT_BASE_NS 1000
`define UNIT_BASE_CYCLES \
    ((`UNIT_BASE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// ===== ov_fault_pkg.sv
package ov_fault_pkg;

    typedef enum logic [5:0] {
        ST_RUN = 6'h01,
        ST_TOLERATE = 6'h02,
        ST_RETRY_WAIT = 6'h04,
        ST_HOLD_OFF = 6'h08,
        ST_LATCHED = 6'h10,
        ST_OFF = 6'h20
    } state_type;

    typedef struct packed {
        logic wr_valid;
        logic rd_valid;
        logic [7:0] code;
        logic [15:0] data;
    } cmd_req_type;

    typedef struct packed {
        logic commanded_on;
        logic bias_ok;
        logic other_fault;
        logic clear_fault;
    } control_in_type;

    typedef struct packed {
        state_type state;
        logic [15:0] threshold;
        logic [7:0] action;
        logic [15:0] delay_unit;
        logic [5:0] cyc_cnt;
        logic [15:0] base_cnt;
        logic [7:0] unit_cnt;
        logic [2:0] attempts;
        logic ov;
        logic output_on;
        logic [15:0] rd_data;
        logic rd_ack;
        logic cmd_error;
    } core_type;

endpackage

// ===== ov_fault_props.sv
`timescale 1ns/1ps
module ov_fault_props (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Command port
    input wire ov_fault_pkg::cmd_req_type cmd_req,
    input wire logic [15:0] rd_data,
    input wire logic rd_ack,
    input wire logic cmd_error,
    // Measurement and control
    input wire logic [15:0] vin_measured,
    input wire ov_fault_pkg::control_in_type control_in,
    // Status
    input wire logic output_enable,
    input wire logic ov_fault,
    input wire logic fault_latched,
    input wire logic [2:0] retry_attempts
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    property p_rd_ack;
        cmd_req.rd_valid |=> rd_ack;
    endproperty
    a_rd_ack: assert property (p_rd_ack)
        else $error("read not answered");
    property p_ack_cause;
        !cmd_req.rd_valid |=> !rd_ack;
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("spurious ack");
    property p_rd_hold;
        !rd_ack |-> $stable(rd_data);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved");
    property p_err_cause;
        cmd_error |-> $past(cmd_req.wr_valid) || $past(cmd_req.rd_valid);
    endproperty
    a_err_cause: assert property (p_err_cause)
        else $error("error without command");
    property p_latched_off;
        fault_latched |-> !output_enable;
    endproperty
    a_latched_off: assert property (p_latched_off)
        else $error("output on while latched");
    property p_latch_hold;
        fault_latched && !control_in.clear_fault && control_in.commanded_on &&
            control_in.bias_ok && !control_in.other_fault |=> fault_latched;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latch lost");
    property p_stop;
        !control_in.commanded_on || !control_in.bias_ok ||
            control_in.other_fault |=> !output_enable;
    endproperty
    a_stop: assert property (p_stop)
        else $error("output not stopped");
    property p_attempts;
        retry_attempts <= 3'h6;
    endproperty
    a_attempts: assert property (p_attempts)
        else $error("too many tries");
endmodule

bind input_overvoltage_fault_handler ov_fault_props props (.clock(clock),
    .reset_n(reset_n), .cmd_req(cmd_req), .rd_data(rd_data), .rd_ack(rd_ack),
    .cmd_error(cmd_error), .vin_measured(vin_measured),
    .control_in(control_in), .output_enable(output_enable),
    .ov_fault(ov_fault), .fault_latched(fault_latched),
    .retry_attempts(retry_attempts));

// ===== tb.sv
`timescale 1ns/1ps
`include "ov_fault_params.svh"
module tb;
    logic clock;
    logic reset_n;
    ov_fault_pkg::cmd_req_type cmd_req;
    ov_fault_pkg::control_in_type control_in;
    logic [15:0] vin_measured;
    logic [15:0] rd_data;
    logic rd_ack;
    logic cmd_error;
    logic output_enable;
    logic ov_fault;
    logic fault_latched;
    logic [2:0] retry_attempts;
    int failures;
    int compares;
    int n;
    logic [15:0] v;
    logic a;
    localparam logic [15:0] VLOW = 16'h0010;
    localparam logic [15:0] VHIGH = 16'h0040;

    input_overvoltage_fault_handler dut (.clock(clock), .reset_n(reset_n),
        .cmd_req(cmd_req), .rd_data(rd_data), .rd_ack(rd_ack),
        .cmd_error(cmd_error), .vin_measured(vin_measured),
        .control_in(control_in), .output_enable(output_enable),
        .ov_fault(ov_fault), .fault_latched(fault_latched),
        .retry_attempts(retry_attempts));
    host_model host (.clock(clock), .cmd_req(cmd_req), .rd_data(rd_data),
        .rd_ack(rd_ack));

    initial begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic cycles(input int c);
        repeat (c) @(posedge clock);
        #1;
    endtask
    task automatic set_vin(input logic [15:0] x);
        @(posedge clock);
        vin_measured <= x;
    endtask
    task automatic wait_oe(input logic val, input int lim);
        n = 0;
        while (output_enable !== val && n < lim) begin
            cycles(1);
            n++;
        end
        chk(n < lim, 1);
    endtask
    task automatic clear();
        set_vin(VLOW);
        @(posedge clock);
        control_in.clear_fault <= 1'h1;
        @(posedge clock);
        control_in.clear_fault <= 1'h0;
        wait_oe(1'h1, 10);
    endtask
    task automatic t_registers();
        host.rd(`CMD_OV_FAULT_THRESHOLD, v, a);
        chk({a, v}, {1'h1, `RST_OV_FAULT_THRESHOLD});
        host.rd(`CMD_OV_FAULT_ACTION, v, a);
        chk(v, {8'h00, `RST_OV_FAULT_ACTION});
        host.rd(`CMD_DELAY_UNIT, v, a);
        chk(v, `RST_DELAY_UNIT);
        host.rd(8'h00, v, a);
        chk({a, cmd_error, v}, {2'h3, 16'h0000});
        host.wr(`CMD_OV_STATUS, 16'h00FF);
        @(posedge clock);
        chk(cmd_error, 1);
        host.wr(`CMD_OV_FAULT_THRESHOLD, 16'h0032);
        host.wr(`CMD_DELAY_UNIT, 16'h0001);
        host.rd(`CMD_OV_FAULT_THRESHOLD, v, a);
        chk(v, 16'h0032);
        host.rd(`CMD_DELAY_UNIT, v, a);
        chk(v, 16'h0001);
    endtask
    task automatic t_ignore();
        host.wr(`CMD_OV_FAULT_ACTION, 16'h0000);
        set_vin(VHIGH);
        cycles(60);
        chk(ov_fault, 1);
        chk(output_enable, 1);
        set_vin(VLOW);
        cycles(3);
    endtask
    task automatic t_disable();
        host.wr(`CMD_OV_FAULT_ACTION, {8'h00, 2'h2, 3'h2, 3'h1});
        set_vin(VHIGH);
        cycles(3);
        chk(output_enable, 0);
        cycles(150);
        chk(fault_latched, 0);
        cycles(20);
        chk({fault_latched, retry_attempts}, {1'h1, 3'h2});
        host.rd(`CMD_OV_STATUS, v, a);
        chk({a, v}, {1'h1, 16'h0090});
        set_vin(VLOW);
        cycles(40);
        chk(output_enable, 0);
        clear();
    endtask
    task automatic t_tolerate();
        host.wr(`CMD_OV_FAULT_ACTION, {8'h00, 2'h1, 3'h0, 3'h0});
        set_vin(VHIGH);
        cycles(30);
        chk(output_enable, 1);
        cycles(20);
        chk({output_enable, fault_latched}, 2'h1);
        clear();
    endtask
    task automatic t_resume();
        host.wr(`CMD_OV_FAULT_ACTION, 16'h00C0);
        set_vin(VHIGH);
        cycles(53);
        chk(output_enable, 0);
        set_vin(VLOW);
        wait_oe(1'h1, 5);
    endtask
    task automatic t_forever();
        host.wr(`CMD_OV_FAULT_ACTION, {8'h00, 2'h2, 3'h7, 3'h0});
        set_vin(VHIGH);
        cycles(400);
        chk({fault_latched, output_enable}, 2'h0);
        set_vin(VLOW);
        wait_oe(1'h1, 50);
        @(posedge clock);
        control_in.bias_ok <= 1'h0;
        cycles(4);
        chk(output_enable, 0);
        @(posedge clock);
        control_in.bias_ok <= 1'h1;
        wait_oe(1'h1, 10);
        @(posedge clock);
        control_in.other_fault <= 1'h1;
        cycles(2);
        chk(output_enable, 0);
        @(posedge clock);
        control_in.other_fault <= 1'h0;
        control_in.commanded_on <= 1'h0;
        cycles(2);
        chk(output_enable, 0);
        @(posedge clock);
        control_in.commanded_on <= 1'h1;
        wait_oe(1'h1, 10);
    endtask
    task automatic stop_test();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clock);
        failures++;
        stop_test();
    end
    initial begin
        reset_n = 1'h0;
        control_in = '{1'h0, 1'h1, 1'h0, 1'h0};
        vin_measured = VLOW;
        repeat (3) @(posedge clock);
        reset_n <= 1'h1;
        t_registers();
        @(posedge clock);
        control_in.commanded_on <= 1'h1;
        wait_oe(1'h1, 10);
        t_ignore();
        t_disable();
        t_tolerate();
        t_resume();
        t_forever();
        stop_test();
    end
endmodule
